// ==== hdl/sss_supervisor.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_supervisor #(
  parameter int TICK_CYC = `SSS_TICK_CYC,
  parameter int PUD_TICKS = `SSS_PUD_TICKS,
  parameter int FLT_TICKS = `SSS_FLT_TICKS,
  parameter int POR_TICKS = `SSS_POR_TICKS,
  parameter int SS_STEP_TICKS = `SSS_SS_STEP_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enable and comparator results
  input wire logic enable_in,
  input wire sss_pkg::sss_sense_type sense,
  // Supply control
  output sss_pkg::sss_ctrl_type ctrl,
  // Open-drain power-good: output level and enable
  output logic power_good_out,
  output logic power_good_oe,
  // Open-drain keep-alive good: output level and enable
  output logic keepalive_good_out,
  output logic keepalive_good_oe,
  // Status
  output logic standby_out
);
  import sss_pkg::*;

  localparam int FLT_CW = $clog2(FLT_TICKS + 1);
  localparam int POR_CW = $clog2(POR_TICKS + 1);
  localparam int STEP_CW = $clog2(SS_STEP_TICKS + 1);

  // Elaboration checks on the timing parameters
  if (PUD_TICKS * `SSS_TICK_US < `SSS_PUD_MIN_US ||
      PUD_TICKS * `SSS_TICK_US > `SSS_PUD_MAX_US) begin : g_bad_pud
    $error("PUD_TICKS outside power-up delay window");
  end
  if (FLT_TICKS < 1) begin : g_bad_flt
    $error("FLT_TICKS must be at least 1");
  end
  if (POR_TICKS < 1) begin : g_bad_por
    $error("POR_TICKS must be at least 1");
  end
  if (SS_STEP_TICKS < 1) begin : g_bad_step
    $error("SS_STEP_TICKS must be at least 1");
  end
  // The code ramp from half to full scale must span the step count
  if (int'(`SSS_SS_FULL_CODE) - int'(`SSS_SS_HALF_CODE) + 1 !=
      `SSS_SS_STEPS) begin : g_bad_ramp
    $error("Soft-start code ramp does not match the step count");
  end

  // Time base and power-up timer results
  logic tick;
  logic batt_done;
  logic ka_batt_done;
  logic run_req;

  // Sequencer state and counters
  sss_state_type state_ff;
  sss_state_type nxt_state;
  logic [FLT_CW-1:0] flt_cnt_ff;
  logic [FLT_CW-1:0] nxt_flt_cnt;
  logic [POR_CW-1:0] por_cnt_ff;
  logic [POR_CW-1:0] nxt_por_cnt;
  logic [STEP_CW-1:0] step_cnt_ff;
  logic [STEP_CW-1:0] nxt_step_cnt;
  logic [4:0] ss_code_ff;
  logic [4:0] nxt_ss_code;
  logic por_done_ff;
  logic nxt_por_done;

  // Output registers
  sss_ctrl_type ctrl_ff;
  sss_ctrl_type nxt_ctrl;
  logic pg_oe_ff;
  logic nxt_pg_oe;
  logic ka_oe_ff;
  logic nxt_ka_oe;
  logic standby_ff;
  logic nxt_standby;

  // Both regulator outputs above their power-good thresholds
  function automatic logic outputs_above_pg(input sss_sense_type s);
    return s.main_above_pg && s.low_above_pg;
  endfunction

  // Both regulator outputs inside their regulation range
  function automatic logic outputs_in_range(input sss_sense_type s);
    return s.main_in_range && s.low_in_range;
  endfunction

  // Both battery inputs adequate right now
  function automatic logic supplies_ok(input sss_sense_type s);
    return s.battery_ok && s.keepalive_battery_ok;
  endfunction

  // States in which the switching regulator runs
  function automatic logic gate_on(input sss_state_type st);
    return (st == SSS_SOFTSTART) || (st == SSS_POR_WAIT) || (st == SSS_RUN);
  endfunction

  // Last tick of a count that runs from zero to ticks minus one
  function automatic logic at_last(input logic [31:0] cnt, input int ticks);
    return cnt == 32'(ticks - 1);
  endfunction

  // Slow time base
  sss_tick_gen #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Power-up delay timers, one per battery input, idle in standby
  sss_delay_timer #(
    .TICKS(PUD_TICKS)
  ) u_batt_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(enable_in && sense.battery_ok),
    .done(batt_done)
  );

  sss_delay_timer #(
    .TICKS(PUD_TICKS)
  ) u_ka_batt_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(enable_in && sense.keepalive_battery_ok),
    .done(ka_batt_done)
  );

  // Start only while both timers expired and both supplies are still adequate
  assign run_req = batt_done && ka_batt_done && supplies_ok(sense);

  // Sequencer next state and timer counts
  always_comb begin
    nxt_state = state_ff;
    nxt_flt_cnt = flt_cnt_ff;
    nxt_por_cnt = por_cnt_ff;
    nxt_step_cnt = step_cnt_ff;
    nxt_ss_code = ss_code_ff;
    nxt_por_done = por_done_ff;
    // Enable low wins over every state
    if (!enable_in) begin
      nxt_state = SSS_STANDBY;
      nxt_flt_cnt = '0;
      nxt_por_cnt = '0;
      nxt_por_done = 1'b0;
      nxt_ss_code = `SSS_SS_HALF_CODE;
      nxt_step_cnt = '0;
    end else begin
      unique case (state_ff)
        SSS_STANDBY: begin
          // Enable back high is the wake-up request
          nxt_state = SSS_QUALIFY;
        end
        SSS_QUALIFY: begin
          // Ramp parked at half scale until both timers expire
          nxt_ss_code = `SSS_SS_HALF_CODE;
          nxt_step_cnt = '0;
          nxt_por_done = 1'b0;
          if (run_req) begin
            nxt_state = SSS_SOFTSTART;
          end
        end
        SSS_SOFTSTART: begin
          // Main output dropping during the last step also faults
          if (!sense.main_above_pg && ss_code_ff == `SSS_SS_FULL_CODE) begin
            nxt_state = SSS_FAULT_OFF;
          end else if (tick) begin
            if (at_last(32'(step_cnt_ff), SS_STEP_TICKS)) begin
              nxt_step_cnt = '0;
              if (ss_code_ff == `SSS_SS_FULL_CODE) begin
                // Soft-start ends after the last step
                if (!outputs_in_range(sense)) begin
                  nxt_state = SSS_FAULT_OFF;
                end else begin
                  nxt_state = SSS_POR_WAIT;
                  nxt_por_cnt = '0;
                end
              end else begin
                nxt_ss_code = ss_code_ff + 5'h01;
              end
            end else begin
              nxt_step_cnt = step_cnt_ff + 1'b1;
            end
          end
        end
        SSS_POR_WAIT, SSS_RUN: begin
          // Any output drop aborts timing and shuts the regulator off
          if (!outputs_above_pg(sense)) begin
            nxt_state = SSS_FAULT_OFF;
            nxt_por_done = 1'b0;
          end else if (state_ff == SSS_POR_WAIT && tick) begin
            nxt_por_cnt = por_cnt_ff + 1'b1;
            if (at_last(32'(por_cnt_ff), POR_TICKS)) begin
              nxt_por_done = 1'b1;
              nxt_state = SSS_RUN;
            end
          end
        end
        SSS_FAULT_OFF: begin
          // Hold the regulator off, then retry qualification
          nxt_por_done = 1'b0;
          if (tick) begin
            nxt_flt_cnt = flt_cnt_ff + 1'b1;
            if (at_last(32'(flt_cnt_ff), FLT_TICKS)) begin
              nxt_flt_cnt = '0;
              nxt_state = SSS_QUALIFY;
            end
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SSS_STANDBY;
      flt_cnt_ff <= '0;
      por_cnt_ff <= '0;
      step_cnt_ff <= '0;
      ss_code_ff <= `SSS_SS_HALF_CODE;
      por_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      flt_cnt_ff <= nxt_flt_cnt;
      por_cnt_ff <= nxt_por_cnt;
      step_cnt_ff <= nxt_step_cnt;
      ss_code_ff <= nxt_ss_code;
      por_done_ff <= nxt_por_done;
    end
  end

  // Registered outputs derived from next state and comparator results
  always_comb begin
    nxt_standby = (nxt_state == SSS_STANDBY);
    nxt_ctrl.keepalive_reg_en = 1'b1;
    nxt_ctrl.switcher_gate_en = gate_on(nxt_state);
    nxt_ctrl.low_reg_en = nxt_ctrl.switcher_gate_en;
    nxt_ctrl.main_pulldown = nxt_standby;
    nxt_ctrl.low_pulldown = nxt_standby;
    nxt_ctrl.ss_target = nxt_ss_code;
    // Release only when timer expired and both outputs above thresholds
    nxt_pg_oe = !(nxt_por_done && outputs_above_pg(sense));
    if (nxt_standby) begin
      nxt_pg_oe = 1'b1;
    end
    nxt_ka_oe = !sense.keepalive_above_ref;
  end

  // Output registers, reset to the standby levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= '{switcher_gate_en: 1'b0, main_pulldown: 1'b1, low_pulldown: 1'b1,
                   low_reg_en: 1'b0, keepalive_reg_en: 1'b1,
                   ss_target: `SSS_SS_HALF_CODE};
      pg_oe_ff <= 1'b1;
      ka_oe_ff <= 1'b1;
      standby_ff <= 1'b1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pg_oe_ff <= nxt_pg_oe;
      ka_oe_ff <= nxt_ka_oe;
      standby_ff <= nxt_standby;
    end
  end

  // Ports driven straight from the output registers, open-drain data levels tied low
  assign ctrl = ctrl_ff;
  assign power_good_out = 1'b0; // Open drain only ever drives low
  assign power_good_oe = pg_oe_ff;
  assign keepalive_good_out = 1'b0;
  assign keepalive_good_oe = ka_oe_ff;
  assign standby_out = standby_ff;
endmodule

// ==== hdl/sss_params.svh ====
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
// Clock rate
`define SSS_CLK_HZ 100000000
`define SSS_CLK_KHZ 100000
// Power-up delay window in microseconds (1.0 ms to 10 ms)
`define SSS_PUD_MIN_US 1000
`define SSS_PUD_MAX_US 10000
// Fault-off window in microseconds (1.0 ms to 10 ms)
`define SSS_FLT_MIN_US 1000
`define SSS_FLT_MAX_US 10000
// Power-on reset window in microseconds (5.0 ms to 15 ms)
`define SSS_POR_MIN_US 5000
`define SSS_POR_MAX_US 15000
// Soft-start window in microseconds (5.0 ms to 15 ms)
`define SSS_SS_MIN_US 5000
`define SSS_SS_MAX_US 15000
// Soft-start step count and starting code
`define SSS_SS_STEPS 16
`define SSS_SS_HALF_CODE 5'h10
`define SSS_SS_FULL_CODE 5'h1f
// Time base tick period in microseconds
`define SSS_TICK_US 10
// Cycles per tick derived from clock rate
`define SSS_TICK_CYC ((`SSS_TICK_US * `SSS_CLK_KHZ) / 1000)
// Tick counts chosen inside each window
`define SSS_PUD_TICKS (2000 / `SSS_TICK_US)
`define SSS_FLT_TICKS (2000 / `SSS_TICK_US)
`define SSS_POR_TICKS (10000 / `SSS_TICK_US)
`define SSS_SS_STEP_TICKS (500 / `SSS_TICK_US)
`endif

// ==== hdl/sss_pkg.sv ====
package sss_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    SSS_STANDBY,
    SSS_QUALIFY,
    SSS_SOFTSTART,
    SSS_POR_WAIT,
    SSS_RUN,
    SSS_FAULT_OFF
  } sss_state_type;

  // Comparator results, all active high meaning adequate or in range
  typedef struct packed {
    logic battery_ok;
    logic keepalive_battery_ok;
    logic main_above_pg;
    logic low_above_pg;
    logic main_in_range;
    logic low_in_range;
    logic keepalive_above_ref;
  } sss_sense_type;

  // Supply control outputs
  typedef struct packed {
    logic switcher_gate_en;
    logic main_pulldown;
    logic low_pulldown;
    logic low_reg_en;
    logic keepalive_reg_en;
    logic [4:0] ss_target;
  } sss_ctrl_type;
endpackage

// ==== hdl/sss_tick_gen.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_tick_gen #(
  parameter int TICK_CYC = `SSS_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Slow time base pulse
  output logic tick
);
  localparam int CW = $clog2(TICK_CYC + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Elaboration check: the divider needs at least two cycles per tick
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  // Divider producing one-cycle enable
  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 1'b1;
    if (cnt_ff == CW'(TICK_CYC - 1)) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule

// ==== hdl/sss_delay_timer.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_delay_timer #(
  parameter int TICKS = `SSS_PUD_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Time base and qualification
  input wire logic tick,
  input wire logic run,
  // Expiry level, held while run stays high
  output logic done
);
  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // Elaboration check: a timer of zero ticks could never expire
  if (TICKS < 1) begin : g_bad_ticks
    $error("TICKS must be at least 1");
  end

  // Count ticks while qualified, clear when not
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (!run) begin
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end else if (!done_ff && tick) begin
      nxt_cnt = cnt_ff + 1'b1;
      if (cnt_ff == CW'(TICKS - 1)) begin
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule

// ==== sim/sss_supervisor_sva.sv ====
`timescale 1ns/1ps
module sss_supervisor_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Enable and comparator results
  input wire logic enable_in,
  input wire sss_pkg::sss_sense_type sense,
  // Supply control
  input wire sss_pkg::sss_ctrl_type ctrl,
  // Open-drain pins and status
  input wire logic power_good_out,
  input wire logic power_good_oe,
  input wire logic keepalive_good_out,
  input wire logic keepalive_good_oe,
  input wire logic standby_out
);
  import sss_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Standby entry and what it holds off
  a_enable_low_standby: assert property (!enable_in |=> standby_out)
    else $error("standby not entered after enable low");
  a_standby_drive_off: assert property (standby_out |->
    !ctrl.switcher_gate_en && ctrl.main_pulldown && ctrl.low_pulldown)
    else $error("standby does not hold outputs off");
  // Regulator start and shutdown conditions
  a_gate_after_supply: assert property ($rose(ctrl.switcher_gate_en) |->
    $past(sense.battery_ok) && $past(sense.keepalive_battery_ok))
    else $error("regulator started without adequate supply");
  a_ss_half_start: assert property ($rose(ctrl.switcher_gate_en) |->
    ctrl.ss_target == 5'h10)
    else $error("soft-start did not begin at half scale");
  a_fault_gate_off: assert property (ctrl.switcher_gate_en && !power_good_oe &&
    !sense.low_above_pg |=> !ctrl.switcher_gate_en)
    else $error("regulator kept on after output drop");
  // Power-good and keep-alive good pin behaviour
  a_pg_low_drop: assert property (!(sense.main_above_pg && sense.low_above_pg)
    |=> power_good_oe)
    else $error("power-good not driven low on output drop");
  a_pg_release_cause: assert property ($fell(power_good_oe) |->
    $past(sense.main_above_pg) && $past(sense.low_above_pg) && !standby_out)
    else $error("power-good released without good outputs");
  a_open_drain_low: assert property (!power_good_out && !keepalive_good_out)
    else $error("open-drain data level not low");
  a_keepalive_follow: assert property (1'b1 |=>
    keepalive_good_oe == !$past(sense.keepalive_above_ref))
    else $error("keep-alive good does not follow reference");
  // Main scenarios reached
  c_pg_release: cover property ($fell(power_good_oe));
  c_ss_top: cover property (ctrl.ss_target == 5'h1f);
  c_standby: cover property ($rose(standby_out));
endmodule

// ==== sim/sss_host_model.sv ====
`timescale 1ns/1ps
module sss_host_model (
  // Open-drain power-good pin
  input wire logic power_good_out,
  input wire logic power_good_oe,
  // Host reset level seen on the pulled-up wire
  output logic host_reset_n
);
  // Pull-up raises the wire whenever the pin is released
  assign host_reset_n = power_good_oe ? power_good_out : 1'b1;
endmodule

// ==== sim/supply_sequencing_supervisor_bench.sv ====
`timescale 1ns/1ps
module supply_sequencing_supervisor_bench;
  import sss_pkg::*;
  localparam int TC = 2;
  localparam int PUD = 100;
  localparam int FLT = 3;
  localparam int POR = 3;
  localparam int SS = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable_in = 1'b0;
  sss_sense_type sense = 7'h7f;
  sss_ctrl_type ctrl;
  logic pg_out, pg_oe, kag_out, kag_oe, standby_out, host_reset_n;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  // Clock
  always #5 clk = ~clk;
  sss_supervisor #(.TICK_CYC(TC), .PUD_TICKS(PUD), .FLT_TICKS(FLT), .POR_TICKS(POR),
    .SS_STEP_TICKS(SS)) i_sss_supervisor (.clk(clk), .rst_n(rst_n), .enable_in(enable_in),
    .sense(sense), .ctrl(ctrl), .power_good_out(pg_out), .power_good_oe(pg_oe),
    .keepalive_good_out(kag_out), .keepalive_good_oe(kag_oe), .standby_out(standby_out));
  sss_host_model i_sss_host_model (.power_good_out(pg_out), .power_good_oe(pg_oe),
    .host_reset_n(host_reset_n));
  // Verdict and end of run
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Flag compare
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Code compare
  task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Watched output by index
  function automatic logic [4:0] pick(input int sel);
    case (sel)
      0: return {4'h0, ctrl.switcher_gate_en};
      1: return {4'h0, pg_oe};
      default: return ctrl.ss_target;
    endcase
  endfunction
  // Bounded wait; n holds the cycles spent
  task automatic wait_for(input int sel, input logic [4:0] v, input int lim);
    n = 0;
    while (pick(sel) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Reset leaves the supply in standby
  task automatic t_reset();
    chk1(standby_out, 1'b1);
    chk1(ctrl.switcher_gate_en, 1'b0);
    chk1(ctrl.main_pulldown & ctrl.low_pulldown, 1'b1);
    chk1(pg_oe, 1'b1);
    chk1(ctrl.low_reg_en, 1'b0);
    chk1(host_reset_n, 1'b0);
    chk1(pg_out | kag_out, 1'b0);
  endtask
  // Wake-up with a battery dip, soft-start, then power-good release
  task automatic t_powerup();
    enable_in = 1'b1;
    step(PUD * TC / 2);
    sense.battery_ok = 1'b0;
    step(2);
    sense.battery_ok = 1'b1;
    wait_for(0, 5'h01, PUD * TC * 2);
    chk1(n >= (PUD - 1) * TC, 1'b1);
    chk1(ctrl.switcher_gate_en, 1'b1);
    chk5(ctrl.ss_target, 5'h10);
    chk1(standby_out, 1'b0);
    chk1(ctrl.low_reg_en, 1'b1);
    wait_for(2, 5'h1f, 16 * SS * TC + 20);
    chk5(ctrl.ss_target, 5'h1f);
    chk1(n >= 15 * SS * TC - TC, 1'b1);
    chk1(pg_oe, 1'b1);
    wait_for(1, 5'h00, (SS + POR) * TC + 20);
    chk1(n >= (SS + POR - 1) * TC, 1'b1);
    chk1(host_reset_n, 1'b1);
  endtask
  // Output drop, fault-off hold, retry failing its range check, good retry
  task automatic t_fault();
    sense.low_above_pg = 1'b0;
    sense.low_in_range = 1'b0;
    step(1);
    chk1(pg_oe, 1'b1);
    step(1);
    chk1(ctrl.switcher_gate_en, 1'b0);
    sense.low_above_pg = 1'b1;
    wait_for(0, 5'h01, FLT * TC + 20);
    chk1(n >= (FLT - 2) * TC, 1'b1);
    chk5(ctrl.ss_target, 5'h10);
    wait_for(2, 5'h1f, 16 * SS * TC + 20);
    chk5(ctrl.ss_target, 5'h1f);
    wait_for(0, 5'h00, SS * TC + 20);
    chk1(ctrl.switcher_gate_en, 1'b0);
    chk1(pg_oe, 1'b1);
    sense.low_in_range = 1'b1;
    wait_for(1, 5'h00, (FLT + 17 * SS + POR) * TC + 40);
    chk1(pg_oe, 1'b0);
  endtask
  // Standby from run, keep-alive flag, wake-up restarts qualification
  task automatic t_standby();
    enable_in = 1'b0;
    sense.keepalive_above_ref = 1'b0;
    step(1);
    chk1(standby_out, 1'b1);
    chk1(ctrl.switcher_gate_en | ~ctrl.main_pulldown | ~ctrl.low_pulldown, 1'b0);
    chk1(pg_oe, 1'b1);
    chk1(kag_oe, 1'b1);
    chk1(ctrl.keepalive_reg_en, 1'b1);
    chk1(ctrl.low_reg_en, 1'b0);
    sense.keepalive_above_ref = 1'b1;
    step(1);
    chk1(kag_oe, 1'b0);
    enable_in = 1'b1;
    step(2);
    chk1(standby_out, 1'b0);
    chk1(ctrl.switcher_gate_en, 1'b0);
  endtask
  // Main sequence
  initial begin
    step(12);
    rst_n = 1'b1;
    step(1);
    t_reset();
    t_powerup();
    t_fault();
    t_standby();
    test_done();
  end
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end
endmodule
bind sss_supervisor sss_supervisor_sva i_sss_supervisor_sva (.clk(clk), .rst_n(rst_n),
  .enable_in(enable_in), .sense(sense), .ctrl(ctrl), .power_good_out(power_good_out),
  .power_good_oe(power_good_oe), .keepalive_good_out(keepalive_good_out),
  .keepalive_good_oe(keepalive_good_oe), .standby_out(standby_out));
